// ==== pkg/pwm_pkg.sv ====
// Shared constants and types for the two-channel pulse-width modulator
package pwm_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ          = 25_000_000;
  localparam int BURST_CYCLE_MS  = 5;
  localparam int BURST_CYCLE_CLKS = CLK_HZ / 1000 * BURST_CYCLE_MS;
  localparam int BURST_STEPS     = 256;
  localparam int CLKS_PER_UNIT   = 4;
  localparam int DIV_W           = 17;

  // ****************************************
  // Widths
  // ****************************************
  localparam int NUM_CH   = 2;
  localparam int PERIOD_W = 8;
  localparam int DUTY_W   = 10;
  localparam int COUNT_W  = 10;
  localparam int ADDR_W   = 8;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_PERIOD = 8'h00;
  localparam logic [7:0] ADDR_DUTY1  = 8'h04;
  localparam logic [7:0] ADDR_DUTY2  = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0C;
  localparam logic [7:0] ADDR_BURST  = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT  = 1;
  localparam int CMD_BURST_BIT = 2;
  localparam int CMD_CHAN_BIT  = 3;

  localparam int BURST_LEVEL_LSB  = 0;
  localparam int BURST_CYCLES_LSB = 8;

  localparam int STAT_ACTIVE_LSB = 0;
  localparam int STAT_BURST_BIT  = 2;
  localparam int STAT_LEFT_LSB   = 8;

  localparam logic [7:0]  PERIOD_RST = 8'h00;
  localparam logic [9:0]  DUTY_RST   = 10'h000;
  localparam logic [15:0] BURST_RST  = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic start;
    logic stop;
    logic burst;
    logic chan;
  } cmd_t;

  typedef struct packed {
    logic [7:0] cycles;
    logic [7:0] level;
  } burst_cfg_t;

  typedef enum logic {BURST_IDLE, BURST_RUN} burst_state_t;

endpackage

// ==== hw/pwm_timer.sv ====
// Shared period timer: counts system clocks over one mark-plus-space cycle
`timescale 1ns/10ps
module pwm_timer (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Control
  input  wire logic                          restart_i,
  input  wire logic                          run_i,
  input  wire logic [pwm_pkg::PERIOD_W-1:0]  period_i,
  // Timer state
  output logic      [pwm_pkg::COUNT_W-1:0]   count_o,
  output logic                               wrap_o
);

  logic [pwm_pkg::PERIOD_W-1:0] period_reg;
  logic [pwm_pkg::PERIOD_W-1:0] period_next;
  logic [pwm_pkg::COUNT_W-1:0]  count_reg;
  logic [pwm_pkg::COUNT_W-1:0]  count_next;
  logic [pwm_pkg::COUNT_W-1:0]  last;

  // Cycle is (period+1)*4 clocks, so the last count is period*4+3
  assign last = {period_reg, 2'b11};
  assign wrap_o  = run_i && (count_reg == last);
  assign count_o = count_reg;

  always_comb begin
    period_next = period_reg;
    count_next  = count_reg;
    if (restart_i) begin
      period_next = period_i;
      count_next  = '0;
    end else if (!run_i) begin
      count_next = '0;
    end else if (count_reg == last) begin
      count_next = '0;
    end else begin
      count_next = count_reg + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_reg <= pwm_pkg::PERIOD_RST;
      count_reg  <= '0;
    end else begin
      period_reg <= period_next;
      count_reg  <= count_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_count_bounded: assert property (@(posedge clk_i) disable iff (rst_i)
    count_reg <= last)
    else $error("timer count passed the end of the cycle");

  a_wrap_restarts: assert property (@(posedge clk_i) disable iff (rst_i)
    wrap_o && !restart_i |=> count_reg == '0 && $stable(period_reg))
    else $error("timer did not return to zero after the cycle end");

endmodule // pwm_timer

// ==== hw/pwm_channel.sv ====
// One output channel: duty compare against the shared timer
`timescale 1ns/10ps
module pwm_channel (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Commands
  input  wire logic                         start_i,
  input  wire logic                         stop_i,
  input  wire logic                         duty_wr_i,
  input  wire logic [pwm_pkg::DUTY_W-1:0]   duty_i,
  // Shared timer
  input  wire logic [pwm_pkg::COUNT_W-1:0]  count_i,
  input  wire logic                         wrap_i,
  // Output
  output logic                              out_o,
  output logic                              active_o
);

  logic                        active_reg;
  logic                        active_next;
  logic [pwm_pkg::DUTY_W-1:0]  duty_reg;
  logic [pwm_pkg::DUTY_W-1:0]  duty_next;
  logic [pwm_pkg::DUTY_W-1:0]  pend_reg;
  logic [pwm_pkg::DUTY_W-1:0]  pend_next;
  logic                        pend_valid_reg;
  logic                        pend_valid_next;
  logic                        out_reg;
  logic                        out_next;

  always_comb begin
    active_next     = active_reg;
    duty_next       = duty_reg;
    pend_next       = pend_reg;
    pend_valid_next = pend_valid_reg;
    if (stop_i) begin
      active_next     = 1'b0;
      pend_valid_next = 1'b0;
    end else if (start_i) begin
      active_next     = 1'b1;
      duty_next       = duty_i;
      pend_valid_next = 1'b0;
    end else if (active_reg) begin
      // New duty waits for the cycle boundary to avoid a clipped pulse
      if (wrap_i) begin
        if (duty_wr_i) begin
          duty_next = duty_i;
        end else if (pend_valid_reg) begin
          duty_next = pend_reg;
        end
        pend_valid_next = 1'b0;
      end else if (duty_wr_i) begin
        pend_next       = duty_i;
        pend_valid_next = 1'b1;
      end
    end
    // Mark from cycle start while the count is below the duty
    out_next = active_reg && (count_i < duty_reg);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_reg     <= 1'b0;
      duty_reg       <= pwm_pkg::DUTY_RST;
      pend_reg       <= pwm_pkg::DUTY_RST;
      pend_valid_reg <= 1'b0;
      out_reg        <= 1'b0;
    end else begin
      active_reg     <= active_next;
      duty_reg       <= duty_next;
      pend_reg       <= pend_next;
      pend_valid_reg <= pend_valid_next;
      out_reg        <= out_next;
    end
  end

  assign out_o    = out_reg;
  assign active_o = active_reg;

  // ****************************************
  // Checks
  // ****************************************
  a_duty_boundary: assert property (@(posedge clk_i) disable iff (rst_i)
    !wrap_i && !start_i |=> $stable(duty_reg))
    else $error("duty changed away from a cycle boundary");

  a_mark_start: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(out_reg) |-> $past(count_i) == '0)
    else $error("mark began away from the cycle start");

endmodule // pwm_channel

// ==== hw/pwm_unit.sv ====
// Two-channel pulse-width modulator with APB registers and burst mode
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module pwm_unit #(
  parameter int BURST_CYCLE_CLKS = pwm_pkg::BURST_CYCLE_CLKS
) (
  // Clock and reset
  input  wire logic                          CLK_I,
  input  wire logic                          RST_I,
  // APB slave
  input  wire logic                          PSEL_I,
  input  wire logic                          PENABLE_I,
  input  wire logic                          PWRITE_I,
  input  wire logic [pwm_pkg::ADDR_W-1:0]    PADDR_I,
  input  wire logic [31:0]                   PWDATA_I,
  output logic      [31:0]                   PRDATA_O,
  output logic                               PREADY_O,
  output logic                               PSLVERR_O,
  // Core state
  input  wire logic                          LOWPWR_I,
  // Pins
  output logic      [pwm_pkg::NUM_CH-1:0]    PWM_O,
  output logic      [pwm_pkg::NUM_CH-1:0]    PWM_OE_O
);

  // Burst step length; a cycle is 256 steps, truncated to whole clocks
  localparam int TICK_CLKS = (BURST_CYCLE_CLKS / pwm_pkg::BURST_STEPS < 1) ? 1 :
                             BURST_CYCLE_CLKS / pwm_pkg::BURST_STEPS;
  localparam logic [pwm_pkg::DIV_W-1:0] TICK_LAST = pwm_pkg::DIV_W'(TICK_CLKS - 1);

  // ****************************************
  // APB slave
  // ****************************************
  logic        pready_reg;
  logic        pready_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        access;
  logic        commit;
  logic        mapped;
  logic        wr;

  logic [pwm_pkg::PERIOD_W-1:0] period_reg;
  logic [pwm_pkg::PERIOD_W-1:0] period_next;
  logic [pwm_pkg::DUTY_W-1:0]   duty_reg [pwm_pkg::NUM_CH];
  logic [pwm_pkg::DUTY_W-1:0]   duty_next [pwm_pkg::NUM_CH];
  pwm_pkg::burst_cfg_t          bcfg_reg;
  pwm_pkg::burst_cfg_t          bcfg_next;
  pwm_pkg::cmd_t                cmd;

  logic [pwm_pkg::NUM_CH-1:0]   ch_active;
  logic [pwm_pkg::NUM_CH-1:0]   ch_out;
  logic [pwm_pkg::NUM_CH-1:0]   ch_start;
  logic [pwm_pkg::NUM_CH-1:0]   ch_stop;
  logic [pwm_pkg::NUM_CH-1:0]   ch_duty_wr;
  logic [pwm_pkg::COUNT_W-1:0]  count;
  logic                         wrap;
  logic                         timer_restart;

  pwm_pkg::burst_state_t        bstate_reg;
  pwm_pkg::burst_state_t        bstate_next;
  logic                         bchan_reg;
  logic                         bchan_next;
  logic [7:0]                   bleft_reg;
  logic [7:0]                   bleft_next;
  logic [7:0]                   bstep_reg;
  logic [7:0]                   bstep_next;
  logic [pwm_pkg::DIV_W-1:0]    bdiv_reg;
  logic [pwm_pkg::DIV_W-1:0]    bdiv_next;
  logic                         btick;

  logic [pwm_pkg::NUM_CH-1:0]   pin_reg;
  logic [pwm_pkg::NUM_CH-1:0]   pin_next;
  logic [pwm_pkg::NUM_CH-1:0]   pin_oe_reg;
  logic [pwm_pkg::NUM_CH-1:0]   pin_oe_next;

  assign access = PSEL_I && PENABLE_I;
  assign commit = access && pready_reg;
  assign wr     = commit && PWRITE_I;

  always_comb begin
    if (PADDR_I == pwm_pkg::ADDR_PERIOD) begin
      mapped = 1'b1;
    end else if (PADDR_I == pwm_pkg::ADDR_DUTY1) begin
      mapped = 1'b1;
    end else if (PADDR_I == pwm_pkg::ADDR_DUTY2) begin
      mapped = 1'b1;
    end else if (PADDR_I == pwm_pkg::ADDR_CMD) begin
      mapped = 1'b1;
    end else if (PADDR_I == pwm_pkg::ADDR_BURST) begin
      mapped = 1'b1;
    end else if (PADDR_I == pwm_pkg::ADDR_STATUS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // One wait state: answer lands on the second access cycle
  always_comb begin
    pready_next  = access && !pready_reg;
    pslverr_next = access && !pready_reg && !mapped;
    prdata_next  = 32'h0000_0000;
    if (access && !pready_reg && !PWRITE_I) begin
      if (PADDR_I == pwm_pkg::ADDR_PERIOD) begin
        prdata_next[pwm_pkg::PERIOD_W-1:0] = period_reg;
      end else if (PADDR_I == pwm_pkg::ADDR_DUTY1) begin
        prdata_next[pwm_pkg::DUTY_W-1:0] = duty_reg[0];
      end else if (PADDR_I == pwm_pkg::ADDR_DUTY2) begin
        prdata_next[pwm_pkg::DUTY_W-1:0] = duty_reg[1];
      end else if (PADDR_I == pwm_pkg::ADDR_BURST) begin
        prdata_next[15:0] = bcfg_reg;
      end else if (PADDR_I == pwm_pkg::ADDR_STATUS) begin
        prdata_next[pwm_pkg::STAT_ACTIVE_LSB +: pwm_pkg::NUM_CH] = ch_active;
        prdata_next[pwm_pkg::STAT_BURST_BIT] = (bstate_reg == pwm_pkg::BURST_RUN);
        prdata_next[pwm_pkg::STAT_LEFT_LSB +: 8] = bleft_reg;
      end
    end
  end

  // ****************************************
  // Registers and command decode
  // ****************************************
  always_comb begin
    period_next = period_reg;
    bcfg_next   = bcfg_reg;
    for (int c = 0; c < pwm_pkg::NUM_CH; c++) begin
      duty_next[c] = duty_reg[c];
    end
    cmd = '0;
    if (wr) begin
      if (PADDR_I == pwm_pkg::ADDR_PERIOD) begin
        period_next = PWDATA_I[pwm_pkg::PERIOD_W-1:0];
      end else if (PADDR_I == pwm_pkg::ADDR_DUTY1) begin
        duty_next[0] = PWDATA_I[pwm_pkg::DUTY_W-1:0];
      end else if (PADDR_I == pwm_pkg::ADDR_DUTY2) begin
        duty_next[1] = PWDATA_I[pwm_pkg::DUTY_W-1:0];
      end else if (PADDR_I == pwm_pkg::ADDR_BURST) begin
        bcfg_next.level  = PWDATA_I[pwm_pkg::BURST_LEVEL_LSB +: 8];
        bcfg_next.cycles = PWDATA_I[pwm_pkg::BURST_CYCLES_LSB +: 8];
      end else if (PADDR_I == pwm_pkg::ADDR_CMD) begin
        cmd.start = PWDATA_I[pwm_pkg::CMD_START_BIT];
        cmd.stop  = PWDATA_I[pwm_pkg::CMD_STOP_BIT];
        cmd.burst = PWDATA_I[pwm_pkg::CMD_BURST_BIT];
        cmd.chan  = PWDATA_I[pwm_pkg::CMD_CHAN_BIT];
      end
    end
  end

  always_comb begin
    for (int c = 0; c < pwm_pkg::NUM_CH; c++) begin
      // Halt on low power, explicit stop, a start with zero period or a burst taking the pin
      ch_stop[c] = LOWPWR_I ||
                   (cmd.chan == c[0] && (cmd.stop || cmd.burst)) ||
                   (cmd.chan == c[0] && cmd.start && period_reg == '0);
      ch_start[c] = cmd.chan == c[0] && cmd.start && !cmd.stop && period_reg != '0;
      ch_duty_wr[c] = wr && (PADDR_I == (c == 0 ? pwm_pkg::ADDR_DUTY1 :
                                                  pwm_pkg::ADDR_DUTY2));
    end
  end

  assign timer_restart = |ch_start;

  // ****************************************
  // Shared timer and channels
  // ****************************************
  pwm_timer u_timer (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .restart_i (timer_restart),
    .run_i     (|ch_active),
    .period_i  (period_reg),
    .count_o   (count),
    .wrap_o    (wrap)
  );

  for (genvar g = 0; g < pwm_pkg::NUM_CH; g++) begin : g_ch
    pwm_channel u_ch (
      .clk_i     (CLK_I),
      .rst_i     (RST_I),
      .start_i   (ch_start[g]),
      .stop_i    (ch_stop[g]),
      .duty_wr_i (ch_duty_wr[g]),
      .duty_i    (duty_next[g]),
      .count_i   (count),
      .wrap_i    (wrap),
      .out_o     (ch_out[g]),
      .active_o  (ch_active[g])
    );
  end

  // ****************************************
  // Burst mode
  // ****************************************
  assign btick = (bdiv_reg == TICK_LAST);

  always_comb begin
    bstate_next = bstate_reg;
    bchan_next  = bchan_reg;
    bleft_next  = bleft_reg;
    bstep_next  = bstep_reg;
    bdiv_next   = bdiv_reg;
    case (bstate_reg)
      pwm_pkg::BURST_IDLE: begin
        if (cmd.burst && !LOWPWR_I && bcfg_reg.cycles != 8'h00) begin
          bstate_next = pwm_pkg::BURST_RUN;
          bchan_next  = cmd.chan;
          bleft_next  = bcfg_reg.cycles;
          bstep_next  = 8'h00;
          bdiv_next   = '0;
        end
      end
      pwm_pkg::BURST_RUN: begin
        bdiv_next = btick ? '0 : bdiv_reg + 17'h00001;
        if (LOWPWR_I || (cmd.stop && cmd.chan == bchan_reg)) begin
          bstate_next = pwm_pkg::BURST_IDLE;
          bleft_next  = 8'h00;
        end else if (btick) begin
          bstep_next = bstep_reg + 8'h01;
          if (bstep_reg == 8'hFF) begin
            bleft_next = bleft_reg - 8'h01;
            if (bleft_reg == 8'h01) begin
              bstate_next = pwm_pkg::BURST_IDLE;
            end
          end
        end
      end
      default: bstate_next = pwm_pkg::BURST_IDLE;
    endcase
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_comb begin
    for (int c = 0; c < pwm_pkg::NUM_CH; c++) begin
      if (bstate_reg == pwm_pkg::BURST_RUN && bchan_reg == c[0]) begin
        pin_oe_next[c] = 1'b1;
        pin_next[c]    = bstep_reg < bcfg_reg.level;
      end else begin
        pin_oe_next[c] = ch_active[c];
        // Gate with active so a stopped pin never shows a stale mark
        pin_next[c]    = ch_out[c] & ch_active[c];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      period_reg  <= pwm_pkg::PERIOD_RST;
      bcfg_reg    <= pwm_pkg::BURST_RST;
      for (int c = 0; c < pwm_pkg::NUM_CH; c++) begin
        duty_reg[c] <= pwm_pkg::DUTY_RST;
      end
      bstate_reg  <= pwm_pkg::BURST_IDLE;
      bchan_reg   <= 1'b0;
      bleft_reg   <= 8'h00;
      bstep_reg   <= 8'h00;
      bdiv_reg    <= '0;
      pin_reg     <= '0;
      pin_oe_reg  <= '0;
    end else begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
      period_reg  <= period_next;
      bcfg_reg    <= bcfg_next;
      for (int c = 0; c < pwm_pkg::NUM_CH; c++) begin
        duty_reg[c] <= duty_next[c];
      end
      bstate_reg  <= bstate_next;
      bchan_reg   <= bchan_next;
      bleft_reg   <= bleft_next;
      bstep_reg   <= bstep_next;
      bdiv_reg    <= bdiv_next;
      pin_reg     <= pin_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  assign PREADY_O  = pready_reg;
  assign PRDATA_O  = prdata_reg;
  assign PSLVERR_O = pslverr_reg;
  assign PWM_O     = pin_reg;
  assign PWM_OE_O  = pin_oe_reg;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_start_nonzero;
    cmd.start && !cmd.stop && !LOWPWR_I && period_reg != '0;
  endsequence

  sequence s_burst_last_step;
    bstate_reg == pwm_pkg::BURST_RUN && btick && bstep_reg == 8'hFF && bleft_reg == 8'h01;
  endsequence

  a_zero_period_stop: assert property (@(posedge CLK_I) disable iff (RST_I)
    cmd.start && period_reg == '0 |=> ch_active[$past(cmd.chan)] == 1'b0)
    else $error("start with zero period left the channel running");

  a_start_restarts: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_start_nonzero |=> count == '0 ##1 PWM_OE_O[$past(cmd.chan, 2)])
    else $error("start did not restart the timer and drive the pin");

  a_stop_halts: assert property (@(posedge CLK_I) disable iff (RST_I)
    cmd.stop && !cmd.burst |=> !ch_active[$past(cmd.chan)] ##1 !PWM_O[$past(cmd.chan, 2)])
    else $error("stop command left the output toggling");

  a_lowpower_halt: assert property (@(posedge CLK_I) disable iff (RST_I)
    LOWPWR_I |=> ch_active == '0 && bstate_reg == pwm_pkg::BURST_IDLE)
    else $error("output kept running in low power");

  a_float_reset: assert property (@(posedge CLK_I) disable iff (RST_I)
    $past(RST_I) |-> PWM_OE_O == '0)
    else $error("pin driven straight after reset");

  a_burst_release: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_burst_last_step ##1 !ch_active[bchan_reg] |=> !PWM_OE_O[bchan_reg])
    else $error("pin not released after the last burst cycle");

  a_duty_timer_kept: assert property (@(posedge CLK_I) disable iff (RST_I)
    |ch_duty_wr && !cmd.start && wrap == 1'b0 && |ch_active |=> count == $past(count) + 10'h001)
    else $error("duty update disturbed the timer");

  a_apb_wait: assert property (@(posedge CLK_I) disable iff (RST_I)
    access && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("APB answer not given on the second access cycle");

endmodule // pwm_unit

// ==== verif/pwm_load.sv ====
// Load on the pins: pull-down resistor to ground on each output
`timescale 1ns/10ps
module pwm_load (
  // Pins from the device
  input  wire logic [1:0] pin_i,
  input  wire logic [1:0] oe_i,
  // Wire level seen by the load
  output logic      [1:0] level_o
);
  // Pull-down holds the level low while the pins float
  assign level_o = pin_i & oe_i;
endmodule // pwm_load

// ==== verif/pwm_unit_tb.sv ====
// Self-checking bench for the two-channel modulator
`timescale 1ns/10ps
module pwm_unit_tb;
  typedef struct packed {logic [7:0] p; logic [9:0] d; logic [15:0] len;} row_t;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, lowpwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic        rdy, serr, err;
  logic [1:0]  pwm, oe, lvl;
  int          num_errors = 0, n_checks = 0, hi, len;
  // Duty kept within four times the period
  row_t        rows [4] = '{'{8'h01, 10'h003, 16'h8}, '{8'h04, 10'h00A, 16'h14},
                            '{8'h02, 10'h001, 16'hC}, '{8'hFF, 10'h3FC, 16'h400}};
  always #20 clk = ~clk;
  pwm_unit #(.BURST_CYCLE_CLKS(512)) dut_u (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(rdy), .PSLVERR_O(serr), .LOWPWR_I(lowpwr), .PWM_O(pwm), .PWM_OE_O(oe));
  pwm_load load_u (.pin_i(pwm), .oe_i(oe), .level_o(lvl));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; padr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    err = serr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic meas(input int ch);
    hi = 0;
    while (lvl[ch] !== 1'b0) @(posedge clk);
    while (lvl[ch] !== 1'b1) @(posedge clk);
    while (lvl[ch] === 1'b1) begin hi++; @(posedge clk); end
    len = hi;
    while (lvl[ch] !== 1'b1) begin len++; @(posedge clk); end
  endtask
  // Timer left to this unit alone: no servo pulses are ever requested
  task automatic run(input logic [7:0] p, input logic [9:0] d);
    apb(1'b1, pwm_pkg::ADDR_PERIOD, {24'h0, p});
    apb(1'b1, pwm_pkg::ADDR_DUTY1, {22'h0, d});
    apb(1'b1, pwm_pkg::ADDR_CMD, 32'h1);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(oe, 2'b00);
    foreach (rows[i]) begin
      apb(1'b0, 8'h00 + 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, pwm_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h18, 32'h5);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, pwm_pkg::ADDR_PERIOD, 32'hFFFF_FFFF);
    apb(1'b0, pwm_pkg::ADDR_PERIOD, 32'h0);
    chk(rd, 32'hFF);
    // ****************************************
    // Table of period and duty cases
    // ****************************************
    foreach (rows[i]) begin
      run(rows[i].p, rows[i].d);
      meas(0);
      chk(hi, {22'h0, rows[i].d});
      chk(len, {16'h0, rows[i].len});
    end
    run(8'h04, 10'h00A);
    apb(1'b1, pwm_pkg::ADDR_DUTY1, 32'h5);
    meas(0);
    chk(hi, 32'd5);
    chk(len, 32'd20);
    apb(1'b1, pwm_pkg::ADDR_DUTY2, 32'h6);
    apb(1'b1, pwm_pkg::ADDR_CMD, 32'h9);
    apb(1'b0, pwm_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h3);
    meas(1);
    chk(hi, 32'd6);
    chk(len, 32'd20);
    apb(1'b1, pwm_pkg::ADDR_CMD, 32'hA);
    repeat (3) @(posedge clk);
    chk(oe, 2'b01);
    run(8'h00, 10'h000);
    repeat (3) @(posedge clk);
    chk(oe, 2'b00);
    run(8'h04, 10'h00A);
    lowpwr <= 1'b1;
    repeat (3) @(posedge clk);
    chk(oe, 2'b00);
    lowpwr <= 1'b0;
    // Burst: two cycles of 512 clocks at half level, sent twice
    apb(1'b1, pwm_pkg::ADDR_BURST, 32'h0280);
    apb(1'b0, pwm_pkg::ADDR_BURST, 32'h0);
    chk(rd, 32'h0280);
    repeat (2) begin
      apb(1'b1, pwm_pkg::ADDR_CMD, 32'h4);
      meas(0);
      chk(hi, 32'd256);
      chk(len, 32'd512);
      repeat (1100) @(posedge clk);
      chk(oe, 2'b00);
    end
    apb(1'b0, pwm_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    report_and_stop();
  end
endmodule // pwm_unit_tb
